// ==== design/gpp_ports.sv ====
// Ports D (pull-up and direction), E and F with their peripheral pin sharing.
// Assumes a classic Wishbone master on clk_sys and pin levels synchronous to it.
`timescale 1ns/100ps
`include "gpp_map.svh"

module gpp_ports (
	input wire logic clk_sys,
	input wire logic rst,
	input wire gpp_pkg::gpp_wb_req_t wbReq,
	output gpp_pkg::gpp_wb_rsp_t wbRsp,
	input wire gpp_pkg::gpp_periph_t periphIn,
	input wire logic [7:0] peIn,
	output logic [7:0] peOut,
	output logic [7:0] peOeN,
	input wire logic [7:0] pfIn,
	output logic [7:0] pfOut,
	output logic [7:0] pfOeN,
	output logic [7:0] pdPullupOn,
	output logic [7:0] pdDirection
);
	import gpp_pkg::*;

	logic [7:0] portDDirection;
	logic [7:0] portDPullupEnable;
	logic [7:0] portEDataLatch;
	logic [7:0] portEDirection;
	logic [7:0] portFDataLatch;
	logic [7:0] portFDirection;
	logic [2:0] periphCtl;
	logic [15:0] edgeLevelSelect;

	logic spiEnable;
	logic spiMaster;
	logic sciEnable;
	logic [7:0] chanActive;
	logic [7:0] eOwn;
	logic [7:0] eOe;
	logic [7:0] eVal;
	logic [7:0] fOwn;
	logic [7:0] fOe;
	logic [7:0] fVal;
	logic [7:0] eRead;
	logic [7:0] fRead;

	logic busHit;
	logic wrEn;
	logic [7:0] regIdx;
	logic [31:0] next_rdData;
	logic busAck;
	logic [31:0] busRdData;

	assign spiEnable = periphCtl[`GPP_PCTL_SPI_EN];
	assign spiMaster = periphCtl[`GPP_PCTL_MSTR];
	assign sciEnable = periphCtl[`GPP_PCTL_SCI];

	// Bus slave: every access is answered one cycle after it is seen, mapped or not.
	assign busHit = wbReq.cyc & wbReq.stb;
	assign wrEn = busHit & busAck & wbReq.we;
	assign regIdx = {2'h0, wbReq.adr[7:2]};

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			busAck <= 1'h0;
		end else begin
			busAck <= busHit & ~busAck;
		end
	end

	// One driver for the whole response word keeps ack and data in a single process each.
	assign wbRsp = '{ack: busAck, dat: busRdData};

	always_comb begin
		next_rdData = 32'h00000000;
		case (regIdx)
			`GPP_OFS_D_DIR >> 2: next_rdData[7:0] = portDDirection;
			`GPP_OFS_D_PUE >> 2: next_rdData[7:0] = portDPullupEnable;
			`GPP_OFS_E_DATA >> 2: next_rdData[7:0] = eRead;
			`GPP_OFS_E_DIR >> 2: next_rdData[7:0] = portEDirection;
			`GPP_OFS_F_DATA >> 2: next_rdData[7:0] = fRead;
			`GPP_OFS_F_DIR >> 2: next_rdData[7:0] = portFDirection;
			`GPP_OFS_PCTL >> 2: next_rdData[2:0] = periphCtl;
			`GPP_OFS_ELS >> 2: next_rdData[15:0] = edgeLevelSelect;
			`GPP_OFS_OWN >> 2: next_rdData[15:0] = {fOwn, eOwn};
			default: next_rdData = 32'h00000000;
		endcase
	end

	// Read data is captured when the request is first seen and held with ack.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			busRdData <= 32'h00000000;
		end else if (busHit & ~busAck & ~wbReq.we) begin
			busRdData <= next_rdData;
		end
	end

	// Direction and control registers have a defined reset state.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			portDDirection <= `GPP_DIR_RST;
			portEDirection <= `GPP_DIR_RST;
			portFDirection <= `GPP_DIR_RST;
		end else if (wrEn & wbReq.sel[0]) begin
			case (regIdx)
				`GPP_OFS_D_DIR >> 2: portDDirection <= wbReq.dat[7:0];
				`GPP_OFS_E_DIR >> 2: portEDirection <= wbReq.dat[7:0];
				`GPP_OFS_F_DIR >> 2: portFDirection <= wbReq.dat[7:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			portDPullupEnable <= `GPP_PUE_RST;
			periphCtl <= `GPP_PCTL_RST;
		end else if (wrEn & wbReq.sel[0]) begin
			case (regIdx)
				`GPP_OFS_D_PUE >> 2: portDPullupEnable <= wbReq.dat[7:0];
				`GPP_OFS_PCTL >> 2: periphCtl <= wbReq.dat[2:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			edgeLevelSelect <= `GPP_ELS_RST;
		end else if (wrEn & (regIdx == (`GPP_OFS_ELS >> 2))) begin
			if (wbReq.sel[0]) begin
				edgeLevelSelect[7:0] <= wbReq.dat[7:0];
			end
			if (wbReq.sel[1]) begin
				edgeLevelSelect[15:8] <= wbReq.dat[15:8];
			end
		end
	end

	// Data latches are deliberately left out of reset so a warm reset keeps them.
	always_ff @(posedge clk_sys) begin
		if (wrEn & wbReq.sel[0]) begin
			if (regIdx == (`GPP_OFS_E_DATA >> 2)) begin
				portEDataLatch <= wbReq.dat[7:0];
			end
			if (regIdx == (`GPP_OFS_F_DATA >> 2)) begin
				portFDataLatch <= wbReq.dat[7:0];
			end
		end
	end

	// Port D pull-ups follow the direction bits without software help.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pdPullupOn <= 8'h00;
			pdDirection <= 8'h00;
		end else begin
			pdPullupOn <= portDPullupEnable & ~portDDirection;
			pdDirection <= portDDirection;
		end
	end

	// A timer channel claims its pin whenever its edge/level pair is not zero.
	always_comb begin
		for (int k = 0; k < `GPP_NUM_TCH; k++) begin
			chanActive[k] = |edgeLevelSelect[2*k +: 2];
		end
	end

	always_comb begin
		eOwn[`GPP_E_SCK] = spiEnable;
		eOwn[`GPP_E_MOSI] = spiEnable;
		eOwn[`GPP_E_MISO] = spiEnable;
		eOwn[`GPP_E_SS] = spiEnable & ~spiMaster;
		eOwn[`GPP_E_TA1] = chanActive[1];
		eOwn[`GPP_E_TA0] = chanActive[0];
		eOwn[`GPP_E_RXD] = sciEnable;
		eOwn[`GPP_E_TXD] = sciEnable;
		eOe[`GPP_E_SCK] = spiMaster;
		eOe[`GPP_E_MOSI] = spiMaster;
		eOe[`GPP_E_MISO] = ~spiMaster;
		eOe[`GPP_E_SS] = 1'h0;
		eOe[`GPP_E_TA1] = periphIn.tmrOe[1];
		eOe[`GPP_E_TA0] = periphIn.tmrOe[0];
		eOe[`GPP_E_RXD] = 1'h0;
		eOe[`GPP_E_TXD] = 1'h1;
		eVal[`GPP_E_SCK] = periphIn.spiSck;
		eVal[`GPP_E_MOSI] = periphIn.spiMosi;
		eVal[`GPP_E_MISO] = periphIn.spiMiso;
		eVal[`GPP_E_SS] = 1'h0;
		eVal[`GPP_E_TA1] = periphIn.tmrOut[1];
		eVal[`GPP_E_TA0] = periphIn.tmrOut[0];
		eVal[`GPP_E_RXD] = 1'h0;
		eVal[`GPP_E_TXD] = periphIn.sciTx;
	end

	// Port F bits 7 and 6 are never shared; bits 5 to 0 go to timer channels 7 to 2.
	always_comb begin
		fOwn = {2'h0, chanActive[7:2]};
		fOe = {2'h0, periphIn.tmrOe[7:2]};
		fVal = {2'h0, periphIn.tmrOut[7:2]};
	end

	for (genvar i = 0; i < 8; i++) begin : g_pin
		gpp_pin_cell u_pe (
			.clk_sys(clk_sys),
			.rst(rst),
			.latch(portEDataLatch[i]),
			.dir(portEDirection[i]),
			.own(eOwn[i]),
			.periphOe(eOe[i]),
			.periphOut(eVal[i]),
			.pinIn(peIn[i]),
			.padOut(peOut[i]),
			.padOeN(peOeN[i]),
			.readBit(eRead[i])
		);
		gpp_pin_cell u_pf (
			.clk_sys(clk_sys),
			.rst(rst),
			.latch(portFDataLatch[i]),
			.dir(portFDirection[i]),
			.own(fOwn[i]),
			.periphOe(fOe[i]),
			.periphOut(fVal[i]),
			.pinIn(pfIn[i]),
			.padOut(pfOut[i]),
			.padOeN(pfOeN[i]),
			.readBit(fRead[i])
		);
	end

	// Checks on the registers and on the registered pin and bus outputs.
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	a_pullup_gate: assert property (
		1'h1 |=> pdPullupOn == $past(portDPullupEnable & ~portDDirection))
		else $error("port D pull-up does not follow enable and direction");

	a_dir_reset: assert property (disable iff (1'h0)
		rst |=> portEDirection == 8'h00 && portFDirection == 8'h00
			&& portDDirection == 8'h00)
		else $error("direction registers not cleared by reset");

	a_e_read_mux: assert property (
		busHit && !wbRsp.ack && !wbReq.we && regIdx == (`GPP_OFS_E_DATA >> 2)
		|=> wbRsp.ack && wbRsp.dat[7:0] == $past((portEDirection & portEDataLatch)
			| (~portEDirection & peIn)))
		else $error("port E read does not mix latch and pin by direction");

	a_e_latch_write: assert property (
		wrEn && wbReq.sel[0] && regIdx == (`GPP_OFS_E_DATA >> 2)
		|=> portEDataLatch == $past(wbReq.dat[7:0]))
		else $error("port E latch write lost");

	a_sck_master: assert property (
		spiEnable && spiMaster
		|=> !peOeN[`GPP_E_SCK] && peOut[`GPP_E_SCK] == $past(periphIn.spiSck))
		else $error("SPI clock not driven as master");

	a_spi_slave_in: assert property (
		spiEnable && !spiMaster |=> peOeN[`GPP_E_SCK] && peOeN[`GPP_E_SS])
		else $error("SPI slave pins not inputs");

	a_spi_off_gpio: assert property (
		!spiEnable |=> peOeN[7:5] == $past(~portEDirection[7:5]))
		else $error("SPI pins do not follow direction while disabled");

	a_sci_pins: assert property (
		sciEnable |=> !peOeN[`GPP_E_TXD] && peOeN[`GPP_E_RXD]
			&& peOut[`GPP_E_TXD] == $past(periphIn.sciTx))
		else $error("serial interface pins not taken over");

	a_timer_f_pin: assert property (
		chanActive[2] |=> pfOeN[0] == $past(!periphIn.tmrOe[2]))
		else $error("timer-owned port F pin follows direction");

	a_ack_pulse: assert property (
		wbRsp.ack |=> !wbRsp.ack)
		else $error("ack held longer than one cycle");

	a_ack_answer: assert property (
		busHit && !wbRsp.ack |=> wbRsp.ack)
		else $error("bus request not answered in the next cycle");

	a_d_dir_copy: assert property (
		1'h1 |=> pdDirection == $past(portDDirection))
		else $error("port D direction copy does not follow its register");

	a_ss_master_gpio: assert property (
		spiEnable && spiMaster |=> peOeN[`GPP_E_SS] == $past(!portEDirection[`GPP_E_SS]))
		else $error("slave select pin not a port pin while SPI is master");

	a_e_timer_pin: assert property (
		chanActive[1] |=> peOeN[`GPP_E_TA1] == $past(!periphIn.tmrOe[1])
			&& (peOeN[`GPP_E_TA1] || peOut[`GPP_E_TA1] == $past(periphIn.tmrOut[1])))
		else $error("timer A channel 1 does not own its port E pin");

	a_f_read_mux: assert property (
		busHit && !wbRsp.ack && !wbReq.we && regIdx == (`GPP_OFS_F_DATA >> 2)
		|=> wbRsp.ack && wbRsp.dat[7:0] == $past((portFDirection & portFDataLatch)
			| (~portFDirection & pfIn)))
		else $error("port F read does not mix latch and pin by direction");

	a_f_plain_pins: assert property (
		1'h1 |=> pfOeN[7:6] == $past(~portFDirection[7:6])
			&& pfOut[7:6] == $past(portFDirection[7:6] & portFDataLatch[7:6]))
		else $error("unshared port F pins do not follow latch and direction");

	c_e_write: cover property (wrEn && regIdx == (`GPP_OFS_E_DATA >> 2));
	c_serial_on: cover property (sciEnable ##1 !peOeN[`GPP_E_TXD]);
	c_spi_master: cover property (spiEnable && spiMaster ##1 !peOeN[`GPP_E_SCK]);
	c_timer_own: cover property (chanActive[0] ##1 eOwn[`GPP_E_TA0]);
	c_pullup_off: cover property (portDPullupEnable[0] && portDDirection[0]);

endmodule : gpp_ports

// ==== common/gpp_map.svh ====
// Register offsets, field positions and reset values of the shared GPIO port block.
// Assumes a byte-addressed Wishbone bus with one 32-bit word per register.
`ifndef GPP_MAP_SVH
`define GPP_MAP_SVH

`define GPP_OFS_D_DIR 8'h00
`define GPP_OFS_D_PUE 8'h04
`define GPP_OFS_E_DATA 8'h08
`define GPP_OFS_E_DIR 8'h0c
`define GPP_OFS_F_DATA 8'h10
`define GPP_OFS_F_DIR 8'h14
`define GPP_OFS_PCTL 8'h18
`define GPP_OFS_ELS 8'h1c
`define GPP_OFS_OWN 8'h20

`define GPP_DIR_RST 8'h00
`define GPP_PUE_RST 8'h00
`define GPP_PCTL_RST 3'h0
`define GPP_ELS_RST 16'h0000

`define GPP_PCTL_SPI_EN 0
`define GPP_PCTL_MSTR 1
`define GPP_PCTL_SCI 2

`define GPP_E_SCK 7
`define GPP_E_MOSI 6
`define GPP_E_MISO 5
`define GPP_E_SS 4
`define GPP_E_TA1 3
`define GPP_E_TA0 2
`define GPP_E_RXD 1
`define GPP_E_TXD 0

`define GPP_NUM_TCH 8

`endif

// ==== common/gpp_pkg.sv ====
// Types shared by the GPIO port block and its bench.
// Assumes the constants of gpp_map.svh for offsets and field positions.
package gpp_pkg;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} gpp_wb_req_t;

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} gpp_wb_rsp_t;

	// Pin-side signals that the SPI, serial interface and timers drive.
	typedef struct packed {
		logic spiSck;
		logic spiMosi;
		logic spiMiso;
		logic sciTx;
		logic [7:0] tmrOut;
		logic [7:0] tmrOe;
	} gpp_periph_t;

endpackage : gpp_pkg

// ==== design/gpp_pin_cell.sv ====
// One shared port pin: chooses driver and direction, and the bit that a read returns.
// Assumes a synchronous pin level and an owner flag from the port logic.
`timescale 1ns/100ps

module gpp_pin_cell (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic latch,
	input wire logic dir,
	input wire logic own,
	input wire logic periphOe,
	input wire logic periphOut,
	input wire logic pinIn,
	output logic padOut,
	output logic padOeN,
	output logic readBit
);

	logic next_oe;
	logic next_val;

	always_comb begin
		next_oe = own ? periphOe : dir;
		next_val = own ? periphOut : latch;
	end

	// Pad drive is low whenever the buffer is off, so the pin never shows a stale latch.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			padOeN <= 1'h1;
			padOut <= 1'h0;
		end else begin
			padOeN <= ~next_oe;
			padOut <= next_oe ? next_val : 1'h0;
		end
	end

	assign readBit = dir ? latch : pinIn;

endmodule : gpp_pin_cell

// ==== test/gpp_pin_model.sv ====
// Board side of the port E and F pads.
// Assumes active-low pad enables; an undriven pin shows the board level set by the bench.
`timescale 1ns/100ps

module gpp_pin_model (
	input wire logic [7:0] peOut,
	input wire logic [7:0] peOeN,
	input wire logic [7:0] pfOut,
	input wire logic [7:0] pfOeN,
	input wire logic [7:0] extE,
	input wire logic [7:0] extF,
	output logic [7:0] peIn,
	output logic [7:0] pfIn
);
	// A driving pad wins, so reads of driven pins see the driver, not the board.
	assign peIn = (peOeN & extE) | (~peOeN & peOut);
	assign pfIn = (pfOeN & extF) | (~pfOeN & pfOut);
endmodule : gpp_pin_model

// ==== test/test_gpp_ports.sv ====
// Self-checking bench of the shared GPIO port block.
// Assumes the map of gpp_map.svh and the pin model on ports E and F.
`timescale 1ns/100ps
`include "gpp_map.svh"

module test_gpp_ports;
	import gpp_pkg::*;
	logic clk_sys = 0;
	logic rst = 1;
	gpp_wb_req_t wbReq = '0;
	gpp_wb_rsp_t wbRsp;
	gpp_periph_t periphIn = '0;
	logic [7:0] peIn, peOut, peOeN, pfIn, pfOut, pfOeN, pdPullupOn, pdDirection;
	logic [7:0] extE = 8'h3c;
	logic [7:0] extF = 8'h69;
	logic [7:0] regOfs [8] = '{`GPP_OFS_D_DIR, `GPP_OFS_D_PUE, `GPP_OFS_E_DIR,
		`GPP_OFS_F_DIR, `GPP_OFS_PCTL, `GPP_OFS_ELS, `GPP_OFS_OWN, 8'h24};
	logic [31:0] rd;
	int n_errors = 0;
	int num_checks = 0;
	int cycles = 0;

	gpp_ports i_gpp_ports (.clk_sys(clk_sys), .rst(rst), .wbReq(wbReq), .wbRsp(wbRsp),
		.periphIn(periphIn), .peIn(peIn), .peOut(peOut), .peOeN(peOeN), .pfIn(pfIn),
		.pfOut(pfOut), .pfOeN(pfOeN), .pdPullupOn(pdPullupOn), .pdDirection(pdDirection));
	gpp_pin_model i_gpp_pin_model (.peOut(peOut), .peOeN(peOeN), .pfOut(pfOut),
		.pfOeN(pfOeN), .extE(extE), .extF(extF), .peIn(peIn), .pfIn(pfIn));

	initial begin
		forever #5 clk_sys = ~clk_sys;
	end

	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : complete_run

	// The whole sequence needs well under a thousand cycles.
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			n_errors++;
			$display("Error at %0t: timeout", $time);
			complete_run();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : check

	// Ack and read data are taken at the edge where ack is seen high.
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		@(posedge clk_sys);
		wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: dat};
		do begin
			@(posedge clk_sys);
		end while (wbRsp.ack !== 1'b1);
		rd = wbRsp.dat;
		wbReq <= '0;
	endtask : wb

	task automatic rdChk(input logic [7:0] adr, input logic [31:0] exp);
		wb(1'b0, adr, 32'h0);
		check(rd, exp);
	endtask : rdChk

	// Pads follow a register change one edge later.
	task automatic settle();
		repeat (2) @(posedge clk_sys);
		#1;
	endtask : settle

	task automatic padChk(input logic [7:0] oeN, input logic [7:0] out);
		check(peOeN, oeN);
		check(peOut, out);
	endtask : padChk

	initial begin
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		wb(1'b1, `GPP_OFS_D_PUE, 32'hff);
		wb(1'b1, `GPP_OFS_D_DIR, 32'h0f);
		settle();
		check(pdPullupOn, 8'hf0);
		check(pdDirection, 8'h0f);
		wb(1'b1, `GPP_OFS_D_DIR, 32'h0);
		settle();
		check(pdPullupOn, 8'hff);
		$display("Test port D done");
		wb(1'b1, `GPP_OFS_E_DATA, 32'ha5);
		wb(1'b1, `GPP_OFS_E_DIR, 32'h0f);
		settle();
		padChk(8'hf0, 8'h05);
		rdChk(`GPP_OFS_E_DATA, 32'h35);
		wb(1'b1, `GPP_OFS_E_DATA, 32'h5a);
		rdChk(`GPP_OFS_E_DATA, 32'h3a);
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		foreach (regOfs[i]) rdChk(regOfs[i], 32'h0);
		settle();
		padChk(8'hff, 8'h00);
		wb(1'b1, `GPP_OFS_E_DIR, 32'hff);
		rdChk(`GPP_OFS_E_DATA, 32'h5a);
		settle();
		padChk(8'h00, 8'h5a);
		$display("Test port E done");
		wb(1'b1, `GPP_OFS_F_DATA, 32'hc3);
		wb(1'b1, `GPP_OFS_F_DIR, 32'hf0);
		settle();
		check(pfOeN, 8'h0f);
		check(pfOut, 8'hc0);
		rdChk(`GPP_OFS_F_DATA, 32'hc9);
		$display("Test port F done");
		periphIn <= '{spiSck: 1'b1, spiMosi: 1'b0, spiMiso: 1'b1, sciTx: 1'b1,
			tmrOut: 8'h00, tmrOe: 8'hc6};
		wb(1'b1, `GPP_OFS_PCTL, 32'h3);
		settle();
		padChk(8'h20, 8'h9a);
		rdChk(`GPP_OFS_OWN, 32'he0);
		rdChk(`GPP_OFS_E_DATA, 32'h5a);
		wb(1'b1, `GPP_OFS_PCTL, 32'h1);
		settle();
		padChk(8'hd0, 8'h2a);
		rdChk(`GPP_OFS_OWN, 32'hf0);
		extE <= 8'h1c;
		wb(1'b1, `GPP_OFS_E_DIR, 32'h0);
		settle();
		rdChk(`GPP_OFS_E_DATA, 32'h3c);
		$display("Test SPI done");
		wb(1'b1, `GPP_OFS_PCTL, 32'h4);
		settle();
		padChk(8'hfe, 8'h01);
		rdChk(`GPP_OFS_OWN, 32'h03);
		wb(1'b1, `GPP_OFS_PCTL, 32'h0);
		settle();
		padChk(8'hff, 8'h00);
		$display("Test serial done");
		wb(1'b1, `GPP_OFS_E_DIR, 32'hff);
		wb(1'b1, `GPP_OFS_F_DIR, 32'h0);
		wb(1'b1, `GPP_OFS_ELS, 32'h2a96);
		settle();
		padChk(8'h04, 8'h52);
		check(pfOeN, 8'hee);
		check(pfOut, 8'h00);
		rdChk(`GPP_OFS_OWN, 32'h1f0c);
		rdChk(`GPP_OFS_ELS, 32'h2a96);
		$display("Test timers done");
		complete_run();
	end
endmodule : test_gpp_ports
